// File: rtl/cmc_pkg.sv
/*
  constants for the current-mode switcher control core: clock rate, switching
  periods, blanking, delay timers, sense code scaling and register map.
  assumes a 25 MHz core clock and digitised feedback and line sense codes.
*/
package cmc_pkg;
  // ==========================================================
  // clock and switching period
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned NOM_FREQ_HZ = 65_000;
  localparam int unsigned MIN_FREQ_HZ = 25_000;
  localparam int unsigned NOM_PERIOD = CLK_HZ / NOM_FREQ_HZ;
  localparam int unsigned MAX_PERIOD = CLK_HZ / MIN_FREQ_HZ;
  localparam int unsigned MAX_DUTY_PCT = 83;
  localparam int unsigned MIN_ON_NS = 400;
  localparam int unsigned MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PER_W = 10;
  // ==========================================================
  // feedback code scaling (one lsb per 200 mV)
  localparam int unsigned FB_LSB_MV = 200;
  localparam int unsigned FB_MIN_MV = 800;
  localparam int unsigned FB_FULL_MV = 2000;
  localparam int unsigned FB_MIN_CODE = FB_MIN_MV / FB_LSB_MV;
  localparam int unsigned FB_FULL_CODE = FB_FULL_MV / FB_LSB_MV;
  // ==========================================================
  // line sense code scaling (one lsb per 2 volts dc)
  localparam int unsigned HV_LSB_V = 2;
  localparam int unsigned BO_V = 88;
  localparam int unsigned BI_V = 105;
  localparam int unsigned MID_V = 155;
  localparam int unsigned HIGH_V = 235;
  localparam logic [7:0] BO_CODE = 8'(BO_V / HV_LSB_V);
  localparam logic [7:0] BI_CODE = 8'((BI_V + HV_LSB_V - 1) / HV_LSB_V);
  localparam logic [7:0] MID_CODE = 8'((MID_V + HV_LSB_V - 1) / HV_LSB_V);
  localparam logic [7:0] HIGH_CODE = 8'((HIGH_V + HV_LSB_V - 1) / HV_LSB_V);
  localparam logic [7:0] HYS_CODES = 8'h02;
  localparam int unsigned LVL_STEP = 32;
  // ==========================================================
  // delay timers, counted in prescaler ticks
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  localparam int unsigned OLP_MS = 860;
  localparam int unsigned BO_MS = 65;
  localparam int unsigned AC_MS = 56;
  localparam int unsigned XON_US = 1500;
  localparam int unsigned XOFF_US = 500;
  localparam int unsigned OLP_TICKS = OLP_MS * 1000 / TICK_US;
  localparam int unsigned BO_TICKS = BO_MS * 1000 / TICK_US;
  localparam int unsigned AC_TICKS = AC_MS * 1000 / TICK_US;
  localparam int unsigned XON_TICKS = XON_US / TICK_US;
  localparam int unsigned XOFF_TICKS = XOFF_US / TICK_US;
  localparam int unsigned TMR_W = 14;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_OLP = 8'h08;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int unsigned ST_GATE = 0;
  localparam int unsigned ST_BURST = 1;
  localparam int unsigned ST_BROWNOUT = 2;
  localparam int unsigned ST_LINE_FILTER_CAPACITOR = 3;
  localparam int unsigned ST_LATCHED = 4;
  localparam int unsigned ST_MID = 5;
  localparam int unsigned ST_HIGH = 6;
  localparam int unsigned ST_LVL = 8;
endpackage

// File: rtl/cmc_core.sv
/*
  current-mode switcher control core with an apb register slave.
  assumes comparator results and sense codes arrive asynchronously on pins,
  and that presetn is driven by the supply undervoltage lockout.
*/
// The APB interface to the registers and the placing of the registers are this design's own decisions.
// What this block does
// - each oscillator trigger while switching is allowed fires a one-shot that sets the gate latch high
// - pulse-width comparator trip resets the gate latch low
// - overcurrent comparator trip also ends the on pulse
// - on time is cut at 83 percent of the switching period
// - set pulse dominates comparator resets while it is active; duty limit and stop conditions still reset
// - current sense is ignored for the minimum on width after turn-on
// - normal load switching period corresponds to 65 kHz
// - light load lowers frequency with feedback, 25 kHz at 0.8 V
// - feedback below stop threshold suppresses pulses until it rises again
// - accumulated overload reaching 860 ms stops switching
// - overload timer counts up in overload, down otherwise, same rate
// - overload level only advances the timer; current limit ends pulses
// - threshold sets chosen by line rising past 155 and 235 volts
// - line below 88 volts for 65 ms stops output pulses
// - switching resumes only above 105 volts brown-in level
// - line quantised to eight levels; ac present needs an increment per window
// - no increment for 56 ms starts line capacitor discharge
// - discharge path chopped 1.5 ms on, 0.5 ms off, repeatedly
// - latched off, startup source on below 8 V, off above 9 V
// - latched state clears only when supply drops below off threshold
// - lockout holds gate low and clears protection latches
`timescale 1ns/100ps
`default_nettype none
module cmc_core #(
  parameter int unsigned TICK_CYCLES = cmc_pkg::TICK_CYC,
  parameter int unsigned OLP_LIMIT = cmc_pkg::OLP_TICKS,
  parameter int unsigned BO_LIMIT = cmc_pkg::BO_TICKS,
  parameter int unsigned AC_LIMIT = cmc_pkg::AC_TICKS,
  parameter int unsigned XON_LIMIT = cmc_pkg::XON_TICKS,
  parameter int unsigned XOFF_LIMIT = cmc_pkg::XOFF_TICKS
) (
  // clock and lockout reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // comparator results
  input wire logic pwm_comparator,
  input wire logic overcurrent_comparator,
  input wire logic overload_comparator,
  input wire logic feedback_stop,
  input wire logic latch_request,
  input wire logic vcc_below_low,
  input wire logic vcc_above_high,
  // digitised sense codes
  input wire logic [3:0] feedback_input,
  input wire logic [7:0] high_voltage_sense,
  // outputs
  output logic gate_drive,
  output logic startup_on,
  output logic line_filter_capacitor_discharge,
  output logic line_level_mid_threshold,
  output logic line_level_high_threshold
);
  import cmc_pkg::*;

  // ==========================================================
  // input synchronisers
  localparam int unsigned SW = 19;
  logic [SW-1:0] raw, s1_q, s2_q, s3_q, f_q;
  assign raw = {high_voltage_sense, feedback_input, vcc_above_high,
                vcc_below_low, latch_request, feedback_stop,
                overload_comparator, overcurrent_comparator, pwm_comparator};

  // three stages; a bit changes only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  logic pwm_f, ocp_f, olp_f, stop_f, lreq_f, vlo_f, vhi_f;
  logic [3:0] fb_f;
  logic [7:0] hv_f;
  assign pwm_f = f_q[0];
  assign ocp_f = f_q[1];
  assign olp_f = f_q[2];
  assign stop_f = f_q[3];
  assign lreq_f = f_q[4];
  assign vlo_f = f_q[5];
  assign vhi_f = f_q[6];
  assign fb_f = f_q[10:7];
  assign hv_f = f_q[18:11];

  // ==========================================================
  // period lookup from feedback code
  function automatic logic [PER_W-1:0] period_for(input logic [3:0] c);
    int unsigned k;
    k = int'(c);
    if (k >= FB_FULL_CODE)
      return PER_W'(NOM_PERIOD);
    else if (k <= FB_MIN_CODE)
      return PER_W'(MAX_PERIOD);
    else
      return PER_W'(MAX_PERIOD - (k - FB_MIN_CODE) * (MAX_PERIOD - NOM_PERIOD)
                    / (FB_FULL_CODE - FB_MIN_CODE));
  endfunction

  // ==========================================================
  // registers and state
  logic [31:0] ctrl_q;
  logic [PER_W-1:0] per_q, per_cnt_q, on_cnt_q, max_on_q;
  logic [3:0] os_cnt_q;
  logic gate_q, latched_q, bo_q, line_filter_capacitor_q, xdis_q, mid_q, high_q, start_q;
  logic [11:0] tick_cnt_q;
  logic tick;
  logic [TMR_W-1:0] olp_cnt_q, bo_cnt_q, ac_cnt_q;
  logic ovl_seen_q, olp_trip;
  logic [2:0] lvl_q;
  logic lvl_inc;
  logic [4:0] chop_cnt_q;
  logic chop_on_q;
  logic run, trig;

  // switching allowed only when enabled and no stop condition holds
  assign run = ctrl_q[CTRL_EN_BIT] & ~stop_f & ~bo_q & ~latched_q;
  assign trig = (per_cnt_q == per_q - PER_W'(1));

  // ==========================================================
  // oscillator: free running period counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= '0;
      per_q <= PER_W'(NOM_PERIOD);
      max_on_q <= PER_W'(NOM_PERIOD * MAX_DUTY_PCT / 100);
    end else if (trig) begin
      // new length taken only at a period boundary to avoid short periods
      per_cnt_q <= '0;
      per_q <= period_for(fb_f);
      max_on_q <= PER_W'(int'(period_for(fb_f)) * MAX_DUTY_PCT / 100);
    end else begin
      per_cnt_q <= per_cnt_q + PER_W'(1);
    end
  end

  // ==========================================================
  // output latch with one-shot set and blanking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
      os_cnt_q <= '0;
      on_cnt_q <= '0;
    end else if (trig && run) begin
      gate_q <= 1'b1;
      os_cnt_q <= 4'(MIN_ON_CYC);
      on_cnt_q <= '0;
    end else if (gate_q) begin
      on_cnt_q <= on_cnt_q + PER_W'(1);
      if (on_cnt_q + PER_W'(1) >= max_on_q || !run)
        gate_q <= 1'b0;
      else if (os_cnt_q != '0)
        os_cnt_q <= os_cnt_q - 4'h1;
      else if (pwm_f || ocp_f)
        gate_q <= 1'b0;
    end
  end

  // ==========================================================
  // shared prescaler for every delay timer
  assign tick = (tick_cnt_q == 12'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 12'h001;
  end

  // ==========================================================
  // overload timer: up in overload, down otherwise, equal rate
  assign olp_trip = tick && ovl_seen_q && (olp_cnt_q == TMR_W'(OLP_LIMIT - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      olp_cnt_q <= '0;
      ovl_seen_q <= 1'b0;
    end else begin
      // an overload in the tick cycle itself counts for the next tick
      if (tick)
        ovl_seen_q <= olp_f;
      else if (olp_f)
        ovl_seen_q <= 1'b1;
      if (tick && ovl_seen_q && !olp_trip)
        olp_cnt_q <= olp_cnt_q + TMR_W'(1);
      else if (tick && !ovl_seen_q && olp_cnt_q != '0)
        olp_cnt_q <= olp_cnt_q - TMR_W'(1);
    end
  end

  // ==========================================================
  // latched off state and startup source hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      latched_q <= 1'b0;
    else if (olp_trip || lreq_f)
      latched_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      start_q <= 1'b0;
    else if (!latched_q)
      start_q <= 1'b0;
    else if (vlo_f)
      start_q <= 1'b1;
    else if (vhi_f)
      start_q <= 1'b0;
  end

  // ==========================================================
  // brownout and brown-in; starts stopped until the line is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_q <= 1'b1;
      bo_cnt_q <= '0;
    end else if (bo_q) begin
      bo_cnt_q <= '0;
      if (hv_f >= BI_CODE)
        bo_q <= 1'b0;
    end else if (hv_f >= BO_CODE) begin
      bo_cnt_q <= '0;
    end else if (tick) begin
      if (bo_cnt_q == TMR_W'(BO_LIMIT - 1))
        bo_q <= 1'b1;
      else
        bo_cnt_q <= bo_cnt_q + TMR_W'(1);
    end
  end

  // ==========================================================
  // line level threshold set selection, rising edges with small hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_q <= 1'b0;
      high_q <= 1'b0;
    end else begin
      if (hv_f >= MID_CODE)
        mid_q <= 1'b1;
      else if (hv_f < MID_CODE - HYS_CODES)
        mid_q <= 1'b0;
      if (hv_f >= HIGH_CODE)
        high_q <= 1'b1;
      else if (hv_f < HIGH_CODE - HYS_CODES)
        high_q <= 1'b0;
    end
  end

  // ==========================================================
  // eight level quantiser with hysteresis around each boundary
  logic [8:0] up_edge, dn_edge;
  assign up_edge = 9'((int'(lvl_q) + 1) * LVL_STEP) + 9'(HYS_CODES);
  assign dn_edge = 9'(int'(lvl_q) * LVL_STEP) - 9'(HYS_CODES);
  assign lvl_inc = (lvl_q != 3'h7) && ({1'b0, hv_f} >= up_edge);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lvl_q <= '0;
    else if (lvl_inc)
      lvl_q <= lvl_q + 3'h1;
    else if (lvl_q != 3'h0 && {1'b0, hv_f} < dn_edge)
      lvl_q <= lvl_q - 3'h1;
  end

  // ==========================================================
  // ac presence window; no increment for a whole window starts discharge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_cnt_q <= '0;
      line_filter_capacitor_q <= 1'b0;
    end else if (lvl_inc) begin
      ac_cnt_q <= '0;
      line_filter_capacitor_q <= 1'b0;
    end else if (tick && !line_filter_capacitor_q) begin
      if (ac_cnt_q == TMR_W'(AC_LIMIT - 1))
        line_filter_capacitor_q <= 1'b1;
      else
        ac_cnt_q <= ac_cnt_q + TMR_W'(1);
    end
  end

  // discharge chopper; the on phase comes first after entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_cnt_q <= '0;
      chop_on_q <= 1'b1;
      xdis_q <= 1'b0;
    end else begin
      xdis_q <= line_filter_capacitor_q & chop_on_q;
      if (!line_filter_capacitor_q) begin
        chop_cnt_q <= '0;
        chop_on_q <= 1'b1;
      end else if (tick) begin
        if (chop_on_q && chop_cnt_q == 5'(XON_LIMIT - 1)) begin
          chop_on_q <= 1'b0;
          chop_cnt_q <= '0;
        end else if (!chop_on_q && chop_cnt_q == 5'(XOFF_LIMIT - 1)) begin
          chop_on_q <= 1'b1;
          chop_cnt_q <= '0;
        end else begin
          chop_cnt_q <= chop_cnt_q + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // apb slave: one wait-free access phase, answer prepared in setup
  logic setup, access;
  logic [31:0] rd_d;
  logic err_d;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;

  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      REG_CTRL: rd_d = ctrl_q;
      REG_STATUS: begin
        rd_d[ST_GATE] = gate_q;
        rd_d[ST_BURST] = stop_f;
        rd_d[ST_BROWNOUT] = bo_q;
        rd_d[ST_LINE_FILTER_CAPACITOR] = line_filter_capacitor_q;
        rd_d[ST_LATCHED] = latched_q;
        rd_d[ST_MID] = mid_q;
        rd_d[ST_HIGH] = high_q;
        rd_d[ST_LVL +: 3] = lvl_q;
      end
      REG_OLP: rd_d[TMR_W-1:0] = olp_cnt_q;
      default: err_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= err_d;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // writable control word; only the enable bit is implemented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= CTRL_RST;
    else if (access && pwrite && paddr == REG_CTRL)
      ctrl_q <= pwdata & 32'h0000_0001;
  end

  // ==========================================================
  // pin outputs, all from flops
  assign gate_drive = gate_q;
  assign startup_on = start_q;
  assign line_filter_capacitor_discharge = xdis_q;
  assign line_level_mid_threshold = mid_q;
  assign line_level_high_threshold = high_q;
endmodule
`default_nettype wire

// File: sim/cmc_core_sva.sv
/*
  checker for the current-mode core, bound to its top-level ports.
  assumes pclk is the only clock and presetn the lockout reset.
*/
`timescale 1ns/100ps
`default_nettype none
module cmc_core_sva (
  // clock and lockout
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // control pins
  input wire logic feedback_stop,
  input wire logic vcc_above_high,
  input wire logic gate_drive,
  input wire logic startup_on,
  input wire logic line_filter_capacitor_discharge
);
  // ==========================================================
  // on-time counter: too long for a repetition, so it is counted here
  int on_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 0;
    end else begin
      on_q <= gate_drive ? on_q + 1 : 0;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_quiet: assert property (!$past(presetn) |-> !gate_drive && !startup_on && !line_filter_capacitor_discharge)
    else $error("output active just after lockout");
  a_blank_hold: assert property ($rose(gate_drive) |-> gate_drive[*8] ##1 gate_drive ##1 gate_drive)
    else $error("pulse shorter than minimum on width");
  a_min_off: assert property ($fell(gate_drive) |-> !gate_drive[*8])
    else $error("second pulse inside one period");
  a_max_on: assert property (on_q <= 830)
    else $error("on time beyond duty limit");
  a_burst_quiet: assert property (feedback_stop[*8] |-> !gate_drive)
    else $error("pulse during burst pause");
  a_startup_high: assert property (vcc_above_high[*8] |-> !startup_on)
    else $error("startup source on above upper level");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_apb_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready && paddr > 8'h08 |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (pready && (paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08) |-> !pslverr)
    else $error("error on mapped access");
endmodule
bind cmc_core cmc_core_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .feedback_stop(feedback_stop), .vcc_above_high(vcc_above_high),
  .gate_drive(gate_drive), .startup_on(startup_on),
  .line_filter_capacitor_discharge(line_filter_capacitor_discharge)
);
`default_nettype wire

// File: sim/cmc_power_stage.sv
/*
  power switch and sense network model: switch current ramps while the gate
  is high; with the gate low the current is zero and every comparator reads low.
  assumes the core clock; set points come from the bench in cycles of on time.
*/
`timescale 1ns/100ps
`default_nettype none
module cmc_power_stage (
  // clock and gate
  input wire logic pclk,
  input wire logic gate_drive,
  // set points
  input wire logic [11:0] pwm_dly,
  input wire logic [11:0] ocp_dly,
  input wire logic olp_en,
  // comparator results
  output logic pwm_comparator,
  output logic overcurrent_comparator,
  output logic overload_comparator
);
  // ==========================================================
  // current ramp restarts at each turn-on; a zero set point models turn-on surge
  logic [11:0] ramp_q;
  always_ff @(posedge pclk) begin
    ramp_q <= gate_drive ? ramp_q + 12'h001 : 12'h000;
  end
  // comparators; the overload level sits below the limit so it reads high all on time
  assign pwm_comparator = gate_drive && (ramp_q >= pwm_dly);
  assign overcurrent_comparator = gate_drive && (ramp_q >= ocp_dly);
  assign overload_comparator = olp_en && gate_drive;
endmodule
`default_nettype wire

// File: sim/test_current_mode_switcher_control.sv
/*
  testbench for the current-mode core: registers, gate timing, burst, line
  sets, discharge, brownout and overload latch-off.
  assumes the power stage model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module test_current_mode_switcher_control;
  import cmc_pkg::*;
  // ==========================================================
  // shortened timers and signals
  localparam int TK = 10;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, hv = 8'h00, hv_base = 8'h3c;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pwm_c, ocp_c, olp_c, gate, st_on, xd, lmid, lhigh;
  logic feedback_stop = 1'b0, vcc_below_low = 1'b0, vcc_above_high = 1'b0, ac_on = 1'b0, olp_en = 1'b0, lreq = 1'b0;
  logic [3:0] fb = 4'ha;
  logic [11:0] pwm_dly = 12'h032, ocp_dly = 12'hfff;
  int cyc = 0, ac_cnt = 0, err_total = 0, compares = 0;
  cmc_core #(.TICK_CYCLES(TK), .OLP_LIMIT(20), .BO_LIMIT(10), .AC_LIMIT(10), .XON_LIMIT(3)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_comparator(pwm_c),
    .overcurrent_comparator(ocp_c), .overload_comparator(olp_c), .feedback_stop(feedback_stop),
    .latch_request(lreq), .vcc_below_low(vcc_below_low), .vcc_above_high(vcc_above_high),
    .feedback_input(fb), .high_voltage_sense(hv), .gate_drive(gate), .startup_on(st_on),
    .line_filter_capacitor_discharge(xd), .line_level_mid_threshold(lmid), .line_level_high_threshold(lhigh));
  cmc_power_stage ps (.pclk(pclk), .gate_drive(gate), .pwm_dly(pwm_dly), .ocp_dly(ocp_dly), .olp_en(olp_en),
    .pwm_comparator(pwm_c), .overcurrent_comparator(ocp_c), .overload_comparator(olp_c));
  // ==========================================================
  // clock, hang guard, and a live line that steps two levels every 32 cycles
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      conclude();
    end
  end
  always @(posedge pclk) begin
    ac_cnt <= ac_cnt + 1;
    if (ac_on && ac_cnt % 32 == 0) hv <= (hv == hv_base) ? hv_base + 8'h40 : hv_base;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("BAD t=%0t got %0h expected %0h", $time, g, x);
    end
  endtask
  task automatic rng(input int g, input int lo, input int hi);
    chk({31'h0, g >= lo && g <= hi}, 32'h1);
  endtask
  // apb transfer: request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // next whole gate pulse: rise time and width in cycles
  task automatic pulse(output int t, output int w);
    int n;
    n = 0;
    w = 0;
    while (gate === 1'b1) @(negedge pclk);
    while (gate !== 1'b1 && n < 4000) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, n < 4000}, 32'h1);
    t = cyc;
    while (gate === 1'b1) begin
      @(negedge pclk);
      w++;
    end
  endtask
  task automatic rises(input int n, output int k);
    logic g;
    k = 0;
    g = gate;
    repeat (n) begin
      @(negedge pclk);
      if (gate === 1'b1 && g !== 1'b1) k++;
      g = gate;
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic s_regs();
    logic [31:0] r;
    logic e;
    rd(REG_CTRL, 32'hffff_ffff, CTRL_RST, 1'b0);
    rd(REG_OLP, 32'h3fff, 32'h0, 1'b0);
    rd(REG_STATUS, 32'h1 << ST_BROWNOUT, 32'h1 << ST_BROWNOUT, 1'b0);
    apb(1'b1, 8'h0c, 32'h1, r, e);
    rd(8'h0c, 32'hffff_ffff, 32'h0, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0, r, e);
    rd(REG_CTRL, 32'h1, 32'h0, 1'b0);
    apb(1'b1, REG_CTRL, 32'h1, r, e);
  endtask
  task automatic s_gate();
    int t1, t2, w;
    ac_on = 1'b1;
    pulse(t1, w);
    pulse(t1, w);
    rng(w, 50, 60);
    pulse(t2, w);
    chk(32'(t2 - t1), 32'h180);
    pwm_dly = 12'h000;
    pulse(t1, w);
    rng(w, 10, 16);
    pwm_dly = 12'hfff;
    pulse(t1, w);
    pulse(t1, w);
    chk(32'(w), 32'h13e);
    ocp_dly = 12'h028;
    pulse(t1, w);
    rng(w, 40, 50);
    ocp_dly = 12'hfff;
  endtask
  task automatic s_freq();
    int t1, t2, w;
    logic [3:0] c[5] = '{4'h2, 4'h4, 4'h7, 4'hc, 4'ha};
    int p[5] = '{1000, 1000, 692, 384, 384};
    pwm_dly = 12'h032;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      fb <= c[i];
      pulse(t1, w);
      pulse(t1, w);
      pulse(t2, w);
      chk(32'(t2 - t1), 32'(p[i]));
    end
  endtask
  task automatic s_burst();
    int t, w, k;
    pulse(t, w);
    @(posedge pclk);
    feedback_stop <= 1'b1;
    rises(1200, k);
    chk(32'(k), 32'h0);
    rd(REG_STATUS, 32'h1 << ST_BURST, 32'h1 << ST_BURST, 1'b0);
    @(posedge pclk);
    feedback_stop <= 1'b0;
    rises(1200, k);
    rng(k, 2, 4);
  endtask
  task automatic s_lines();
    logic [7:0] v[5] = '{8'h3c, 8'h4d, 8'h4e, 8'h75, 8'h76};
    logic [1:0] x[5] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b11};
    ac_on = 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      hv <= v[i];
      repeat (12) @(posedge pclk);
      chk({30'h0, lhigh, lmid}, {30'h0, x[i]});
    end
  endtask
  task automatic s_line_filter_capacitor();
    int n, w;
    @(posedge pclk);
    hv <= 8'h3c;
    repeat (20) @(posedge pclk);
    hv <= 8'h7c;
    repeat (12) @(posedge pclk);
    n = 12;
    while (xd !== 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    rng(n, 95, 125);
    w = 0;
    while (xd === 1'b1 && w < 100) begin
      @(negedge pclk);
      w++;
    end
    chk(32'(w), 32'(3 * TK));
    n = 0;
    while (xd !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n), 32'(XOFF_TICKS * TK));
    @(posedge pclk);
    hv <= 8'h3c;
    repeat (20) @(posedge pclk);
    hv <= 8'h7c;
    repeat (20) @(posedge pclk);
    chk({31'h0, xd}, 32'h0);
    ac_on = 1'b1;
  endtask
  task automatic s_brown();
    int t, w, k;
    pulse(t, w);
    ac_on = 1'b0;
    @(posedge pclk);
    hv <= 8'h28;
    rises(1500, k);
    chk(32'(k), 32'h0);
    @(posedge pclk);
    hv <= 8'h32;
    rises(800, k);
    chk(32'(k), 32'h0);
    ac_on = 1'b1;
    rises(1200, k);
    rng(k, 1, 4);
  endtask
  task automatic s_olp();
    int t, w, k;
    pwm_dly = 12'h064;
    olp_en = 1'b1;
    pulse(t, w);
    rng(w, 100, 110);
    rises(1200, k);
    rng(k, 2, 4);
    pwm_dly = 12'hfff;
    rises(2000, k);
    rises(1200, k);
    chk(32'(k), 32'h0);
    rd(REG_STATUS, 32'h1 << ST_LATCHED, 32'h1 << ST_LATCHED, 1'b0);
    @(posedge pclk);
    vcc_below_low <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({31'h0, st_on}, 32'h1);
    vcc_below_low <= 1'b0;
    vcc_above_high <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({31'h0, st_on}, 32'h0);
    olp_en = 1'b0;
    rises(1000, k);
    chk(32'(k), 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({30'h0, gate, st_on}, 32'h0);
    presetn <= 1'b1;
    vcc_above_high <= 1'b0;
    rd(REG_OLP, 32'h3fff, 32'h0, 1'b0);
    rd(REG_STATUS, 32'h1 << ST_LATCHED, 32'h0, 1'b0);
    rises(1500, k);
    rng(k, 1, 4);
    @(posedge pclk);
    lreq <= 1'b1;
    rises(400, k);
    chk(32'(k), 32'h0);
  endtask
  // ==========================================================
  // verdict and main sequence
  task automatic conclude();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_gate();
    s_freq();
    s_burst();
    s_lines();
    s_line_filter_capacitor();
    s_brown();
    s_olp();
    conclude();
  end
endmodule
`default_nettype wire
